// [design/dcf_core.sv]
// Buffer core: pointers, flags, mark and rewind, mailbox bypass and port width.
`timescale 1ns/10ps
module dcf_core
    import dcf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [10:0] near_full_ofs,
    input wire logic [10:0] near_empty_ofs,
    dcf_if.core pins
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [DCF_AW:0] wptr_q;
    logic [DCF_AW:0] rptr_q;
    logic [DCF_AW:0] mark_q;
    logic [2:0] wsel_q;
    logic init_d1_q;
    logic [DCF_DW-1:0] mask_q;
    logic [DCF_DW-1:0] out_q;
    logic [DCF_DW-1:0] oe_q;
    logic valid_n_q;
    logic full_n_q;
    logic empty_n_q;
    logic half_n_q;
    logic nfull_n_q;
    logic nempty_n_q;
    logic [DCF_DW-1:0] mbox1_q;
    logic [DCF_DW-1:0] mbox2_q;
    logic [1:0] mbox_cnt_q;
    logic [DCF_DW-1:0] rdata;
    logic [DCF_AW:0] count;
    logic [DCF_AW:0] count_w;
    logic [DCF_AW:0] count_r;
    logic do_wr;
    logic do_rd;
    logic [10:0] nf_ofs;
    logic [10:0] ne_ofs;

    // ----------------------------------------
    // Control decode
    // ----------------------------------------
    // The full flag is evaluated from the committed count so a write never
    // overruns; the lag allowance is satisfied with a one-cycle flag.
    // A rewind pulls the read side back to the mark, so the distance is taken from there.
    assign count = wptr_q - (pins.rewind_pulse ? mark_q : rptr_q);
    assign do_wr = !pins.wr_en_n && full_n_q && !pins.passthru_sel;
    assign do_rd = !pins.rd_en_n && empty_n_q && !pins.passthru_sel;
    assign count_w = count + {{DCF_AW{1'b0}}, do_wr};
    assign count_r = count - {{DCF_AW{1'b0}}, do_rd && !pins.rewind_pulse};
    // Offsets are clamped into the legal programmable range.
    assign nf_ofs = (near_full_ofs < DCF_OFS_MIN) ? DCF_OFS_MIN :
        (near_full_ofs > DCF_OFS_MAX) ? DCF_OFS_MAX : near_full_ofs;
    assign ne_ofs = (near_empty_ofs < DCF_OFS_MIN) ? DCF_OFS_MIN :
        (near_empty_ofs > DCF_OFS_MAX) ? DCF_OFS_MAX : near_empty_ofs;

    dcf_mem u_mem (
        .pclk(pclk),
        .we(clk_en && do_wr && !pins.in_en_n && !pins.full_init),
        .waddr(wptr_q[DCF_AW-1:0]),
        .wdata(pins.in_bus & mask_q),
        .raddr(rptr_q[DCF_AW-1:0]),
        .rdata(rdata)
    );

    // ----------------------------------------
    // Width selection
    // ----------------------------------------
    // Width is taken on the edge that ends full init and frozen afterwards.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_d1_q <= 1'b0;
            wsel_q <= DCF_WSEL_RST;
        end else if (clk_en) begin
            init_d1_q <= pins.full_init;
            if (pins.full_init) begin
                wsel_q <= pins.width_sel;
            end
        end
    end

    // Decode width into a bit mask for the bus.
    always_comb begin
        case (wsel_q)
            3'h0: mask_q = 36'h0000001FF;
            3'h1: mask_q = 36'h000000FFF;
            3'h2: mask_q = 36'h00000FFFF;
            3'h3: mask_q = 36'h00003FFFF;
            3'h4: mask_q = 36'h0000FFFFF;
            3'h5: mask_q = 36'h000FFFFFF;
            3'h6: mask_q = 36'h0FFFFFFFF;
            default: mask_q = 36'hFFFFFFFFF;
        endcase
    end

    // ----------------------------------------
    // Pointers, mark and rewind
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_q <= '0;
            rptr_q <= '0;
            mark_q <= '0;
        end else if (clk_en) begin
            if (pins.full_init || pins.pointer_init) begin
                wptr_q <= '0;
                rptr_q <= '0;
                mark_q <= '0;
            end else begin
                if (do_wr) begin
                    wptr_q <= wptr_q + 12'h001;
                end
                if (do_rd && pins.replay_point) begin
                    mark_q <= rptr_q;
                end
                if (pins.rewind_pulse) begin
                    rptr_q <= mark_q;
                end else if (do_rd) begin
                    rptr_q <= rptr_q + 12'h001;
                end
            end
        end
    end

    // ----------------------------------------
    // Flags
    // ----------------------------------------
    // Flags come from the next pointer distance, so a rewind also reshapes them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_n_q <= 1'b1;
            half_n_q <= 1'b1;
            nfull_n_q <= 1'b1;
        end else if (clk_en) begin
            if (pins.full_init || pins.pointer_init) begin
                full_n_q <= 1'b1;
                half_n_q <= 1'b1;
                nfull_n_q <= 1'b1;
            end else begin
                full_n_q <= !(count_w >= DCF_FULLCNT);
                half_n_q <= !(count_w >= DCF_HALF);
                nfull_n_q <= !((DCF_FULLCNT - count_w) <= {1'b0, nf_ofs});
            end
        end
    end

    // Read-side flags; empty is low at reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            empty_n_q <= 1'b0;
            nempty_n_q <= 1'b0;
        end else if (clk_en) begin
            if (pins.full_init || pins.pointer_init) begin
                empty_n_q <= 1'b0;
                nempty_n_q <= 1'b0;
            end else begin
                empty_n_q <= (count_r != '0);
                nempty_n_q <= !(count_r <= {1'b0, ne_ofs});
            end
        end
    end

    // ----------------------------------------
    // Output register and mailbox
    // ----------------------------------------
    // Mailbox stages the input in mbox1_q for one cycle then drives it out.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mbox1_q <= '0;
            mbox2_q <= '0;
            mbox_cnt_q <= 2'h0;
        end else if (clk_en) begin
            mbox1_q <= pins.in_bus & mask_q;
            mbox2_q <= mbox1_q;
            if (!pins.passthru_sel) begin
                mbox_cnt_q <= 2'h0;
            end else if (mbox_cnt_q != 2'(DCF_MBOX_LAT)) begin
                mbox_cnt_q <= mbox_cnt_q + 2'h1;
            end
        end
    end

    // Output register; unused lanes are never enabled.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= '0;
            oe_q <= '0;
            valid_n_q <= 1'b1;
        end else if (clk_en) begin
            if (pins.full_init) begin
                out_q <= '0;
                oe_q <= '0;
                valid_n_q <= 1'b1;
            end else if (pins.passthru_sel) begin
                valid_n_q <= 1'b1;
                if (mbox_cnt_q == 2'(DCF_MBOX_LAT) - 2'h1 || mbox_cnt_q == 2'(DCF_MBOX_LAT)) begin
                    out_q <= mbox1_q;
                    oe_q <= mask_q;
                end
            end else if (do_rd && !pins.out_en_n) begin
                out_q <= rdata & mask_q;
                oe_q <= mask_q;
                valid_n_q <= 1'b0;
            end else begin
                oe_q <= (do_rd) ? '0 : oe_q;
                valid_n_q <= 1'b1;
            end
        end
    end

    assign pins.out_bus = out_q;
    assign pins.out_bus_oe = oe_q;
    assign pins.out_valid_n = valid_n_q;
    assign pins.full_n = full_n_q;
    assign pins.empty_n = empty_n_q;
    assign pins.half_full_n = half_n_q;
    assign pins.near_full_n = nfull_n_q;
    assign pins.near_empty_n = nempty_n_q;
endmodule

// [design/dcf_ctrl.sv]
// Controller end: APB registers that drive the core's pins in legal sequences.
`timescale 1ns/10ps
module dcf_ctrl
    import dcf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    dcf_if.ctrl pins
);
    logic [6:0] ctrl_q;
    logic [35:0] wdata_q;
    logic [35:0] rdata_q;
    logic [21:0] ofs_q;
    logic [31:0] prdata_q;
    logic slverr_q;
    logic wr_en_n_q;
    logic rd_en_n_q;
    logic finit_q;
    logic pinit_q;
    logic rew_q;
    logic busy;
    logic acc;
    logic hit;
    dcf_state_t st_q;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign acc = psel && penable && clk_en;
    assign hit = paddr == DCF_REG_CTRL || paddr == DCF_REG_WDATA || paddr == DCF_REG_RDATA
        || paddr == DCF_REG_STAT || paddr == DCF_REG_OFS || paddr == DCF_REG_CMD;
    assign busy = st_q != DCF_IDLE;

    // Zero-wait slave; commands while busy are dropped without an error; only unmapped addresses are flagged as errors.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= {4'h0, DCF_WSEL_RST};
            wdata_q <= '0;
            ofs_q <= {11'h07F, 11'h07F};
            prdata_q <= '0;
            slverr_q <= 1'b0;
        end else if (clk_en) begin
            slverr_q <= psel && !penable && !hit;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    DCF_REG_CTRL: prdata_q <= {25'h0, ctrl_q};
                    DCF_REG_RDATA: prdata_q <= rdata_q[31:0];
                    DCF_REG_STAT: prdata_q <= {21'h0, busy, rdata_q[35:32], pins.out_valid_n,
                        pins.full_n, pins.empty_n, pins.half_full_n, pins.near_full_n,
                        pins.near_empty_n};
                    DCF_REG_OFS: prdata_q <= {10'h0, ofs_q};
                    default: prdata_q <= 32'h00000000;
                endcase
            end
            if (acc && pwrite) begin
                case (paddr)
                    DCF_REG_CTRL: ctrl_q <= pwdata[6:0];
                    DCF_REG_WDATA: wdata_q <= {pwdata[3:0], pwdata};
                    DCF_REG_OFS: ofs_q <= pwdata[21:0];
                    default: ;
                endcase
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = slverr_q;

    // ----------------------------------------
    // Pin sequencer
    // ----------------------------------------
    // Writes always go as a pair so the burst rule holds; a read is one word.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= DCF_IDLE;
            wr_en_n_q <= 1'b1;
            rd_en_n_q <= 1'b1;
            finit_q <= 1'b1;
            pinit_q <= 1'b0;
            rew_q <= 1'b0;
            rdata_q <= '0;
        end else if (clk_en) begin
            pinit_q <= 1'b0;
            rew_q <= 1'b0;
            // The mailbox never strobes valid, so its word is followed while it is selected.
            if (!pins.out_valid_n || ctrl_q[DCF_CTRL_MBOX]) begin
                rdata_q <= pins.out_bus;
            end
            case (st_q)
                DCF_IDLE: begin
                    finit_q <= 1'b0;
                    if (acc && pwrite && paddr == DCF_REG_CMD) begin
                        if (pwdata[DCF_CMD_FINIT]) begin
                            finit_q <= 1'b1;
                            st_q <= DCF_INIT;
                        end else if (pwdata[DCF_CMD_PINIT]) begin
                            pinit_q <= 1'b1;
                        end else if (pwdata[DCF_CMD_REWIND]) begin
                            rew_q <= 1'b1;
                        end else if (pwdata[DCF_CMD_WPAIR] && !ctrl_q[DCF_CTRL_MBOX]) begin
                            wr_en_n_q <= 1'b0;
                            st_q <= DCF_WR0;
                        end else if (pwdata[DCF_CMD_READ] && !ctrl_q[DCF_CTRL_MBOX]) begin
                            rd_en_n_q <= 1'b0;
                            st_q <= DCF_RD;
                        end
                    end
                end
                DCF_INIT: st_q <= DCF_IDLE;
                DCF_WR0: st_q <= DCF_WR1;
                DCF_WR1: begin
                    wr_en_n_q <= 1'b1;
                    st_q <= DCF_IDLE;
                end
                DCF_RD: begin
                    rd_en_n_q <= 1'b1;
                    st_q <= DCF_IDLE;
                end
                default: st_q <= DCF_IDLE;
            endcase
        end
    end

    assign pins.full_init = finit_q;
    assign pins.pointer_init = pinit_q;
    assign pins.rewind_pulse = rew_q;
    assign pins.wr_en_n = wr_en_n_q;
    assign pins.rd_en_n = rd_en_n_q;
    assign pins.in_bus = wdata_q;
    assign pins.width_sel = ctrl_q[2:0];
    assign pins.in_en_n = !ctrl_q[DCF_CTRL_INEN];
    assign pins.out_en_n = !ctrl_q[DCF_CTRL_OUTEN];
    assign pins.replay_point = ctrl_q[DCF_CTRL_MARK];
    assign pins.passthru_sel = ctrl_q[DCF_CTRL_MBOX];
endmodule

// [design/dcf_if.sv]
// Pin-level interface joining the buffer core and its controller.
`timescale 1ns/10ps
interface dcf_if;
    logic full_init;
    logic pointer_init;
    logic [2:0] width_sel;
    logic wr_en_n;
    logic in_en_n;
    logic [35:0] in_bus;
    logic rd_en_n;
    logic out_en_n;
    logic [35:0] out_bus;
    logic [35:0] out_bus_oe;
    logic out_valid_n;
    logic full_n;
    logic empty_n;
    logic half_full_n;
    logic near_full_n;
    logic near_empty_n;
    logic replay_point;
    logic rewind_pulse;
    logic passthru_sel;
    modport core (input full_init, pointer_init, width_sel, wr_en_n, in_en_n, in_bus,
        rd_en_n, out_en_n, replay_point, rewind_pulse, passthru_sel,
        output out_bus, out_bus_oe, out_valid_n, full_n, empty_n, half_full_n,
        near_full_n, near_empty_n);
    modport ctrl (output full_init, pointer_init, width_sel, wr_en_n, in_en_n, in_bus,
        rd_en_n, out_en_n, replay_point, rewind_pulse, passthru_sel,
        input out_bus, out_bus_oe, out_valid_n, full_n, empty_n, half_full_n,
        near_full_n, near_empty_n);
endinterface

// [design/dcf_mem.sv]
// Storage array of the buffer core with per-word write strobe.
`timescale 1ns/10ps
module dcf_mem
    import dcf_pkg::*;
(
    input wire logic pclk,
    input wire logic we,
    input wire logic [DCF_AW-1:0] waddr,
    input wire logic [DCF_DW-1:0] wdata,
    input wire logic [DCF_AW-1:0] raddr,
    output logic [DCF_DW-1:0] rdata
);
    logic [DCF_DW-1:0] mem_q [DCF_DEPTH];

    // Plain array; no reset so it maps to block memory.
    always_ff @(posedge pclk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    // Combinational read keeps the output register one cycle behind the request.
    assign rdata = mem_q[raddr];
endmodule

// [design/dcf_pkg.sv]
// Shared constants and types for the dual-clock buffer core and its controller.
package dcf_pkg;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int DCF_DW = 36;
    localparam int DCF_AW = 11;
    localparam int DCF_DEPTH = 2048;
    localparam logic [DCF_AW:0] DCF_HALF = 12'h400;
    localparam logic [DCF_AW:0] DCF_FULLCNT = 12'h800;
    // ----------------------------------------
    // Offsets and defaults
    // ----------------------------------------
    localparam logic [10:0] DCF_OFS_MIN = 11'h010;
    localparam logic [10:0] DCF_OFS_MAX = 11'h400;
    localparam logic [2:0] DCF_WSEL_RST = 3'h7;
    localparam int DCF_FULL_LAG = 4;
    localparam int DCF_MBOX_LAT = 2;
    // ----------------------------------------
    // APB register offsets of the controller
    // ----------------------------------------
    localparam logic [7:0] DCF_REG_CTRL = 8'h00;
    localparam logic [7:0] DCF_REG_WDATA = 8'h04;
    localparam logic [7:0] DCF_REG_RDATA = 8'h08;
    localparam logic [7:0] DCF_REG_STAT = 8'h0C;
    localparam logic [7:0] DCF_REG_OFS = 8'h10;
    localparam logic [7:0] DCF_REG_CMD = 8'h14;
    // CTRL fields.
    localparam int DCF_CTRL_WSEL = 0;
    localparam int DCF_CTRL_INEN = 3;
    localparam int DCF_CTRL_OUTEN = 4;
    localparam int DCF_CTRL_MARK = 5;
    localparam int DCF_CTRL_MBOX = 6;
    // CMD fields, self clearing.
    localparam int DCF_CMD_FINIT = 0;
    localparam int DCF_CMD_PINIT = 1;
    localparam int DCF_CMD_WPAIR = 2;
    localparam int DCF_CMD_READ = 3;
    localparam int DCF_CMD_REWIND = 4;
    // Controller sequencing states.
    typedef enum logic [2:0] {
        DCF_IDLE = 3'b000,
        DCF_INIT = 3'b001,
        DCF_WR0 = 3'b010,
        DCF_WR1 = 3'b011,
        DCF_RD = 3'b100
    } dcf_state_t;
endpackage

// [dv/dcf_pins_sva.sv]
// Concurrent checks on the pins that join the buffer core and its controller.
`timescale 1ns/10ps
module dcf_pins_sva
    import dcf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic full_init,
    input wire logic pointer_init,
    input wire logic [2:0] width_sel,
    input wire logic [35:0] in_bus,
    input wire logic rd_en_n,
    input wire logic out_en_n,
    input wire logic [35:0] out_bus,
    input wire logic [35:0] out_bus_oe,
    input wire logic out_valid_n,
    input wire logic full_n,
    input wire logic empty_n,
    input wire logic half_full_n,
    input wire logic near_full_n,
    input wire logic near_empty_n,
    input wire logic passthru_sel
);
    // ------------------------------------------------------------
    // Helper logic and properties
    // ------------------------------------------------------------
    localparam int WTAB[8] = '{9, 12, 16, 18, 20, 24, 32, 36};
    logic [2:0] wsel_q;
    logic [35:0] mask;
    logic quiet;

    // The width is followed while full init is high, so it holds the value seen at its end.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wsel_q <= DCF_WSEL_RST;
        end else if (full_init) begin
            wsel_q <= width_sel;
        end
    end

    // Quiet means nothing but a write or a rewind can move the full flag in this cycle.
    assign mask = 36'((37'h1 << WTAB[wsel_q]) - 37'h1);
    assign quiet = rd_en_n && !pointer_init && !full_init;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_VALID_CAUSE: assert property (!out_valid_n |->
        !$past(rd_en_n) && $past(empty_n))
        else $error("valid strobe without a taken read");
    AST_VALID_ON_READ: assert property ((!rd_en_n && empty_n && !out_en_n
        && !passthru_sel && !full_init && !pointer_init) |=> !out_valid_n)
        else $error("taken read gave no valid strobe");
    AST_SKIP_FLOATS: assert property ((!rd_en_n && empty_n && out_en_n) |=>
        out_bus_oe == 36'h0)
        else $error("skipped read drove the bus");
    AST_WIDTH_OE: assert property ((!out_valid_n && !$past(out_en_n)) |->
        out_bus_oe == mask)
        else $error("driven bits differ from the selected width");
    AST_FULL_BLOCKS: assert property ((!full_n && quiet && $past(quiet)) |=> !full_n)
        else $error("full flag released without a read");
    AST_INIT_CLEARS: assert property ($fell(full_init) |-> ##[0:2]
        (!empty_n && full_n && out_bus == 36'h0))
        else $error("full init left data or flags behind");
    // The input is taken at one edge and presented at the next, two edges in all.
    AST_MBOX_PATH: assert property (passthru_sel [*4] |->
        (out_bus & mask) == ($past(in_bus, 2) & mask))
        else $error("mailbox output differs from the input");
    AST_FULL_ORDER: assert property (!full_n |-> !half_full_n && !near_full_n)
        else $error("full without half full or near full");
    AST_NEAR_EMPTY: assert property (!empty_n |-> !near_empty_n)
        else $error("empty without near empty");

    // Main scenarios reached by the bench.
    COV_READ: cover property (!out_valid_n);
    COV_FULL: cover property (!full_n);
    COV_MBOX: cover property (passthru_sel [*4]);
endmodule

// [dv/dual_clock_fifo_core_tb_top.sv]
// Testbench driving the controller over APB with the core on the far side.
`timescale 1ns/10ps
module dual_clock_fifo_core_tb_top
    import dcf_pkg::*;
();
    // ------------------------------------------------------------
    // Harness, bus tasks and test sequence
    // ------------------------------------------------------------
    localparam logic [31:0] WA = 32'h1234_5678;
    localparam logic [31:0] WB = 32'h9ABC_DEF0;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic last_err;
    logic [31:0] rv;
    int num_errors;
    int comparisons;
    int w;

    dcf_if pins ();
    dcf_ctrl i_dcf_ctrl (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins));
    // Offsets are tied at the floor so near empty clears above 16 words and near full sets within 16 words of full.
    dcf_core i_dcf_core (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .near_full_ofs(11'h010), .near_empty_ofs(11'h010), .pins(pins));
    dcf_pins_sva i_dcf_pins_sva (.pclk(pclk), .presetn(presetn), .full_init(pins.full_init),
        .pointer_init(pins.pointer_init), .width_sel(pins.width_sel), .in_bus(pins.in_bus),
        .rd_en_n(pins.rd_en_n), .out_en_n(pins.out_en_n), .out_bus(pins.out_bus),
        .out_bus_oe(pins.out_bus_oe), .out_valid_n(pins.out_valid_n), .full_n(pins.full_n),
        .empty_n(pins.empty_n), .half_full_n(pins.half_full_n),
        .near_full_n(pins.near_full_n), .near_empty_n(pins.near_empty_n),
        .passthru_sel(pins.passthru_sel));

    // Free running clock.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("Checked %0d values with %0d mismatches", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // The request is held until pready is seen high; data and error are taken at that edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 64) begin
            num_errors++;
            stop_test();
        end
    endtask

    // Commands are ignored while the sequencer is busy, so each one waits for it to finish.
    task automatic cmd(input int b);
        int n;
        apb(1'b1, DCF_REG_CMD, 32'h1 << b);
        for (n = 0; n < 64; n++) begin
            apb(1'b0, DCF_REG_STAT, 32'h0);
            if (rv[10] === 1'b0) break;
        end
        if (n == 64) begin
            num_errors++;
            stop_test();
        end
    endtask

    task automatic wr2(input logic [31:0] d);
        apb(1'b1, DCF_REG_WDATA, d);
        cmd(DCF_CMD_WPAIR);
    endtask

    task automatic rdx(input logic [31:0] e);
        cmd(DCF_CMD_READ);
        apb(1'b0, DCF_REG_RDATA, 32'h0);
        chk("rdata", {4'h0, rv}, {4'h0, e});
    endtask

    task automatic done(input string nm);
        $display("Test %s finished", nm);
    endtask

    // Main sequence; each block is one test.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        num_errors = 0;
        comparisons = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, DCF_REG_STAT, 32'h0);
        chk("stat", {30'h0, rv[5:0]}, 36'h36);
        apb(1'b0, DCF_REG_RDATA, 32'h0);
        chk("rdata", {4'h0, rv}, 36'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", {35'h0, last_err}, 36'h1);
        done("reset");
        apb(1'b1, DCF_REG_CTRL, 32'h1F);
        wr2(WA);
        wr2(WB);
        rdx(WA);
        rdx(WA);
        rdx(WB);
        rdx(WB);
        rdx(WB);
        apb(1'b0, DCF_REG_STAT, 32'h0);
        chk("empty", {35'h0, rv[3]}, 36'h0);
        done("order");
        cmd(DCF_CMD_PINIT);
        apb(1'b1, DCF_REG_CTRL, 32'h17);
        wr2(WB);
        apb(1'b1, DCF_REG_CTRL, 32'h1F);
        rdx(WA);
        done("mask");
        cmd(DCF_CMD_PINIT);
        wr2(WA);
        wr2(WB);
        apb(1'b1, DCF_REG_CTRL, 32'h0F);
        cmd(DCF_CMD_READ);
        chk("oe", pins.out_bus_oe, 36'h0);
        cmd(DCF_CMD_READ);
        apb(1'b1, DCF_REG_CTRL, 32'h1F);
        rdx(WB);
        done("skip");
        // The mark sits on the second word, so a rewind to zero would be caught.
        cmd(DCF_CMD_PINIT);
        wr2(WA);
        wr2(WB);
        rdx(WA);
        apb(1'b1, DCF_REG_CTRL, 32'h3F);
        rdx(WA);
        apb(1'b1, DCF_REG_CTRL, 32'h1F);
        rdx(WB);
        cmd(DCF_CMD_REWIND);
        rdx(WA);
        rdx(WB);
        rdx(WB);
        apb(1'b0, DCF_REG_STAT, 32'h0);
        chk("empty", {35'h0, rv[3]}, 36'h0);
        done("rewind");
        cmd(DCF_CMD_PINIT);
        for (int k = 1; k <= 1024; k++) begin
            wr2(32'(k));
            if (k inside {8, 9, 511, 512, 1015, 1016, 1024}) begin
                w = 2 * k;
                apb(1'b0, DCF_REG_STAT, 32'h0);
                chk("flags", {31'h0, rv[4:0]},
                    {31'h0, w != 2048, 1'b1, w < 1024, (2048 - w) > 16, w > 16});
            end
        end
        wr2(32'hDEAD_BEEF);
        rdx(32'h1);
        apb(1'b0, DCF_REG_STAT, 32'h0);
        chk("full", {35'h0, rv[4]}, 36'h1);
        done("fill");
        apb(1'b1, DCF_REG_CTRL, 32'h18);
        cmd(DCF_CMD_FINIT);
        apb(1'b1, DCF_REG_CTRL, 32'h18);
        wr2(32'hFFFF_FFFF);
        rdx(32'h1FF);
        chk("oe", pins.out_bus_oe, 36'h1FF);
        done("width");
        apb(1'b1, DCF_REG_WDATA, 32'h0ABC);
        apb(1'b1, DCF_REG_CTRL, 32'h58);
        apb(1'b0, DCF_REG_STAT, 32'h0);
        apb(1'b0, DCF_REG_RDATA, 32'h0);
        chk("mailbox", {4'h0, rv}, 36'h0BC);
        apb(1'b1, DCF_REG_CTRL, 32'h18);
        done("mailbox");
        stop_test();
    end
endmodule
